// file: bench/cc_cfg_asserts.sv
`timescale 1ns/1ps
// ********
// Port checks of the config registers
// ********
module cc_cfg_asserts (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic register_reset,
  input wire logic safety_base_tick,
  input wire logic term_current_low,
  input wire logic battery_switch_request,
  input wire logic charge_done_evt,
  input wire logic [5:0] charge_target_voltage,
  input wire logic [12:0] charge_target_mv,
  input wire logic precharge_handover_level,
  input wire logic [11:0] precharge_handover_mv,
  input wire logic termination_enable,
  input wire logic safety_timer_enable,
  input wire logic [1:0] fast_charge_time_limit,
  input wire logic [3:0] fast_charge_hours,
  input wire logic post_termination_keep_current,
  input wire logic temp_sense_on,
  input wire logic safety_timer_double,
  input wire logic battery_switch_off,
  input wire logic watchdog_expiry,
  input wire logic safety_timer_advance,
  input wire logic charge_terminate,
  input wire logic charge_current_suspend,
  input wire logic battery_switch_on,
  input wire logic charge_done_irq
);
  localparam logic [3:0] HRS [4] = '{4'd3, 4'd5, 4'd8, 4'd12};
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  // Decoded figures follow the fields
  target_mv_a: assert property (charge_target_mv == 13'd3600 + 13'd15 * charge_target_voltage)
    else $error("target voltage figure wrong");
  pre_mv_a: assert property (precharge_handover_mv == (precharge_handover_level ? 12'd3000 : 12'd2800))
    else $error("handover figure wrong");
  hours_a: assert property (fast_charge_hours == HRS[fast_charge_time_limit])
    else $error("charge hours figure wrong");
  // Registered controls; terminate, suspend and switch checks skip the first edge after reset since $past still sees reset
  term_follow_a: assert property ($past(arst_n) |-> charge_terminate ==
      $past(term_current_low && termination_enable)) else $error("termination not gated");
  suspend_keep_a: assert property ($past(arst_n) |-> charge_current_suspend ==
      $past(term_current_low && termination_enable && !post_termination_keep_current))
    else $error("suspend wrong");
  switch_off_a: assert property ($past(arst_n) |-> battery_switch_on ==
      $past(battery_switch_request && !battery_switch_off)) else $error("battery switch wrong");
  done_irq_a: assert property (charge_done_irq |-> $past(charge_done_evt))
    else $error("done interrupt without event");
  reg_reset_a: assert property (register_reset |=> charge_target_voltage == 6'h28 && temp_sense_on &&
      safety_timer_double && !battery_switch_off && termination_enable) else $error("reset pulse ignored");
  expiry_reload_a: assert property (watchdog_expiry |-> ##[0:2] (charge_target_voltage == 6'h28 && temp_sense_on))
    else $error("no reload on expiry");
  advance_a: assert property (safety_timer_advance |-> $past(safety_base_tick) && $past(safety_timer_enable))
    else $error("timer advanced without cause");
endmodule : cc_cfg_asserts
bind cc_charge_config_regs cc_cfg_asserts u_asserts (.*);

// file: bench/cc_host.sv
`timescale 1ns/1ps
// ********
// Serial bus master in front of the config block
// ********
module cc_host (
  input wire logic ref_clk,
  input wire logic sda,
  output logic scl,
  output logic sda_pull
);
  localparam int HALF = 6;
  // Lines start released; SCL only toggles inside frames
  initial begin
    scl = 1'b1;
    sda_pull = 1'b0;
  end
  task automatic hw(input int n);
    repeat (n) @(posedge ref_clk);
  endtask : hw
  // Data moves only while SCL is low, one clock after the fall, so no false START or STOP
  task automatic bitx(input logic b, output logic s);
    sda_pull <= ~b;
    hw(HALF);
    scl <= 1'b1;
    hw(HALF);
    s = sda;
    scl <= 1'b0;
    hw(1);
  endtask : bitx
  task automatic frame_start();
    sda_pull <= 1'b0;
    hw(HALF);
    scl <= 1'b1;
    hw(HALF);
    sda_pull <= 1'b1;
    hw(HALF);
    scl <= 1'b0;
    hw(1);
  endtask : frame_start
  // Every frame ends in STOP, which also restarts the device watchdog when the frame carried the device address
  task automatic frame_stop();
    sda_pull <= 1'b1;
    hw(HALF);
    scl <= 1'b1;
    hw(HALF);
    sda_pull <= 1'b0;
    hw(HALF);
  endtask : frame_stop
  // Eight bits MSB first, then the ninth slot driven as last
  task automatic octet(input logic [7:0] d, input logic last, output logic [7:0] q, output logic a);
    for (int i = 7; i >= 0; i--) begin
      bitx(d[i], q[i]);
    end
    bitx(last, a);
  endtask : octet
  // Register access only through addressed frames
  task automatic xfer(input logic [6:0] dev, input logic [7:0] ptr, input logic [7:0] wd, input logic rnw,
                      output logic [7:0] q, output logic nak);
    logic [7:0] x;
    logic a0, a1, a2;
    frame_start();
    octet({dev, 1'b0}, 1'b1, x, a0);
    octet(ptr, 1'b1, x, a1);
    a2 = 1'b0;
    q = 8'h00;
    if (rnw) begin
      frame_start();
      octet({dev, 1'b1}, 1'b1, x, a2);
      octet(8'hff, 1'b1, q, x[0]);
    end else begin
      octet(wd, 1'b1, x, a2);
    end
    frame_stop();
    nak = a0 | a1 | a2;
  endtask : xfer
endmodule : cc_host

// file: bench/tb.sv
`timescale 1ns/1ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin n_errors++; $display("MISMATCH t=%0t got %h exp %h", $time, g, e); end end
module tb;
  import cc_pkg::*;
  localparam int TICK = 100;
  typedef struct { logic [7:0] p, d, e; logic [15:0] v; } cc_row_type;
  logic ref_clk = 1'b0, arst_n = 1'b0, register_reset = 1'b0, discharge_mode = 1'b0;
  logic power_path_limiting = 1'b0, safety_base_tick = 1'b0, term_current_low = 1'b0;
  logic battery_switch_request = 1'b0, watchdog_restart = 1'b0;
  logic [4:0] evt = 5'h00;
  wire logic [4:0] irq;
  logic scl, sda_pull, sda_oe, sda_out, precharge_handover_level, recharge_margin, discharge_watchdog_on;
  logic termination_enable, safety_timer_enable, post_termination_keep_current, temp_sense_on;
  logic safety_timer_double, battery_switch_off, watchdog_expiry, safety_timer_advance;
  logic charge_terminate, charge_current_suspend, battery_switch_on;
  logic [5:0] charge_target_voltage;
  logic [3:0] fast_charge_hours;
  logic [7:0] watchdog_limit_s, q, t5 = 8'h3a, t6 = 8'hc0, recharge_margin_mv;
  logic nk;
  int n_errors = 0, n_compared = 0;
  wire logic sda = !sda_pull && (!sda_oe || sda_out);
  // Ordinary writes: pointer, data, readback, decoded port view
  cc_row_type rows [9] = '{'{8'h04, 8'h00, 8'h00, 16'h0064}, '{8'h04, 8'hff, 8'hff, 16'hffc8},
    '{8'h05, 8'h00, 8'h00, 16'h0300}, '{8'h05, 8'h22, 8'h22, 16'h0528}, '{8'h05, 8'h5c, 8'h5c, 16'h6850},
    '{8'h05, 8'hf7, 8'hf7, 16'hdca0}, '{8'h06, 8'h35, 8'h35, 16'h2000}, '{8'h06, 8'hca, 8'hca, 16'hc000},
    '{8'h07, 8'h5a, 8'h00, 16'h0000}};
  cc_host host (.ref_clk(ref_clk), .sda(sda), .scl(scl), .sda_pull(sda_pull));
  cc_charge_config_regs #(.TICK_CYC(TICK)) uut (
    .ref_clk(ref_clk), .arst_n(arst_n), .scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
    .register_reset(register_reset), .watchdog_restart(watchdog_restart), .discharge_mode(discharge_mode),
    .power_path_limiting(power_path_limiting), .safety_base_tick(safety_base_tick),
    .term_current_low(term_current_low), .battery_switch_request(battery_switch_request),
    .power_good_evt(evt[4]), .charge_done_evt(evt[3]), .charge_state_evt(evt[2]), .temp_fault_evt(evt[1]),
    .battery_overvolt_evt(evt[0]), .charge_target_voltage(charge_target_voltage), .charge_target_mv(),
    .precharge_handover_level(precharge_handover_level), .precharge_handover_mv(),
    .recharge_margin(recharge_margin), .recharge_margin_mv(recharge_margin_mv),
    .discharge_watchdog_on(discharge_watchdog_on),
    .watchdog_limit_s(watchdog_limit_s), .termination_enable(termination_enable),
    .safety_timer_enable(safety_timer_enable), .fast_charge_time_limit(), .fast_charge_hours(fast_charge_hours),
    .post_termination_keep_current(post_termination_keep_current), .temp_sense_on(temp_sense_on),
    .safety_timer_double(safety_timer_double), .battery_switch_off(battery_switch_off),
    .watchdog_expiry(watchdog_expiry), .safety_timer_advance(safety_timer_advance),
    .charge_terminate(charge_terminate), .charge_current_suspend(charge_current_suspend),
    .battery_switch_on(battery_switch_on), .power_good_irq(irq[4]), .charge_done_irq(irq[3]),
    .charge_state_irq(irq[2]), .temp_fault_irq(irq[1]), .battery_overvolt_irq(irq[0])
  );
  // ********
  // Helpers
  // ********
  function automatic logic [15:0] view(input logic [7:0] p);
    case (p)
      CC_OFS_VOLT: return {charge_target_voltage, precharge_handover_level, recharge_margin, recharge_margin_mv};
      CC_OFS_TMR: return {discharge_watchdog_on, termination_enable, safety_timer_enable,
                          post_termination_keep_current, fast_charge_hours, watchdog_limit_s};
      CC_OFS_MISC: return {temp_sense_on, safety_timer_double, battery_switch_off, 13'h0000};
      default: return 16'h0000;
    endcase
  endfunction : view
  task automatic w(input logic [7:0] p, input logic [7:0] d);
    host.xfer(CC_I2C_ADDR, p, d, 1'b0, q, nk);
    `CHK(nk, 1'b0)
  endtask : w
  task automatic r(input logic [7:0] p, input logic [7:0] e);
    host.xfer(CC_I2C_ADDR, p, 8'h00, 1'b1, q, nk);
    `CHK(q, e)
  endtask : r
  // Sampled at the falling edge so registered outputs have settled
  task automatic outs(input logic [2:0] e);
    repeat (2) @(posedge ref_clk);
    @(negedge ref_clk);
    `CHK({charge_terminate, charge_current_suspend, battery_switch_on}, e)
    @(posedge ref_clk);
  endtask : outs
  task automatic irqs(input logic [4:0] e);
    evt <= 5'h1f;
    @(posedge ref_clk);
    evt <= 5'h00;
    @(negedge ref_clk);
    `CHK(irq, e)
    @(posedge ref_clk);
  endtask : irqs
  // Eight base ticks four cycles apart, advances counted
  task automatic ticks(input int e);
    int n;
    n = 0;
    repeat (8) begin
      safety_base_tick <= 1'b1;
      @(posedge ref_clk);
      safety_base_tick <= 1'b0;
      repeat (3) begin
        @(negedge ref_clk);
        n += int'(safety_timer_advance !== 1'b0);
        @(posedge ref_clk);
      end
    end
    `CHK(n, e)
  endtask : ticks
  // 4400 cycles span one 40 s limit
  task automatic wait_exp(input int e);
    int n;
    n = 0;
    repeat (4400) begin
      @(negedge ref_clk);
      n += int'(watchdog_expiry !== 1'b0);
    end
    @(posedge ref_clk);
    `CHK(n, e)
  endtask : wait_exp
  task automatic summarize();
    $display("errors %0d compared %0d", n_errors, n_compared);
    if (n_errors == 0 && n_compared > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : summarize
  // ********
  // Clock, watchdog and main sequence
  // ********
  initial begin
    forever #10 ref_clk = ~ref_clk;
  end
  // Whole run is near 29k cycles; a hang ends it as a failure
  initial begin
    repeat (90000) @(posedge ref_clk);
    n_errors++;
    summarize();
  end
  initial begin
    repeat (20) @(posedge ref_clk);
    arst_n <= 1'b1;
    term_current_low <= 1'b1;
    battery_switch_request <= 1'b1;
    outs(3'b111);
    foreach (rows[i]) begin
      w(rows[i].p, rows[i].d);
      if (rows[i].p == CC_OFS_TMR) t5 = rows[i].d;
      if (rows[i].p == CC_OFS_MISC) t6 = rows[i].d;
      r(rows[i].p, rows[i].e);
      `CHK(view(rows[i].p), rows[i].v)
      outs({t5[4], t5[4] & ~t5[0], ~t6[5]});
      if (rows[i].p == CC_OFS_MISC) irqs(~rows[i].d[4:0]);
    end
    // Reset pulse mid-run restores every field
    register_reset <= 1'b1;
    @(posedge ref_clk);
    register_reset <= 1'b0;
    r(CC_OFS_VOLT, 8'ha3);
    r(CC_OFS_TMR, 8'h3a);
    r(CC_OFS_MISC, 8'hc0);
    // Foreign address is not acknowledged and writes nothing
    host.xfer(7'h08, CC_OFS_VOLT, 8'h00, 1'b0, q, nk);
    `CHK(nk, 1'b1)
    r(CC_OFS_VOLT, 8'ha3);
    // Watchdog held off in discharge mode, then let run and expire
    w(CC_OFS_TMR, 8'h20);
    w(CC_OFS_MISC, 8'h3f);
    w(CC_OFS_VOLT, 8'h00);
    discharge_mode <= 1'b1;
    wait_exp(0);
    w(CC_OFS_TMR, 8'ha0);
    wait_exp(1);
    watchdog_restart <= 1'b1;
    wait_exp(0);
    watchdog_restart <= 1'b0;
    discharge_mode <= 1'b0;
    r(CC_OFS_VOLT, 8'ha3);
    r(CC_OFS_TMR, 8'hba);
    r(CC_OFS_MISC, 8'he0);
    outs(3'b110);
    irqs(5'h1f);
    // Safety timer halved only while limiting, silent when disabled
    power_path_limiting <= 1'b1;
    ticks(4);
    power_path_limiting <= 1'b0;
    ticks(8);
    w(CC_OFS_TMR, 8'h32);
    ticks(0);
    // Second asynchronous reset in mid-run
    arst_n <= 1'b0;
    repeat (3) @(posedge ref_clk);
    arst_n <= 1'b1;
    r(CC_OFS_VOLT, 8'ha3);
    r(CC_OFS_TMR, 8'h3a);
    r(CC_OFS_MISC, 8'hc0);
    `CHK({temp_sense_on, safety_timer_double}, 2'b11)
    summarize();
  end
endmodule : tb

// file: logic/cc_charge_config_regs.sv
`timescale 1ns/1ps
module cc_charge_config_regs
  import cc_pkg::*;
#(
  parameter int TICK_CYC = CC_SEC_CYC
) (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic register_reset,
  input wire logic watchdog_restart,
  input wire logic discharge_mode,
  input wire logic power_path_limiting,
  input wire logic safety_base_tick,
  input wire logic term_current_low,
  input wire logic battery_switch_request,
  input wire logic power_good_evt,
  input wire logic charge_done_evt,
  input wire logic charge_state_evt,
  input wire logic temp_fault_evt,
  input wire logic battery_overvolt_evt,
  output logic [5:0] charge_target_voltage,
  output logic [12:0] charge_target_mv,
  output logic precharge_handover_level,
  output logic [11:0] precharge_handover_mv,
  output logic recharge_margin,
  output logic [7:0] recharge_margin_mv,
  output logic discharge_watchdog_on,
  output logic [7:0] watchdog_limit_s,
  output logic termination_enable,
  output logic safety_timer_enable,
  output logic [1:0] fast_charge_time_limit,
  output logic [3:0] fast_charge_hours,
  output logic post_termination_keep_current,
  output logic temp_sense_on,
  output logic safety_timer_double,
  output logic battery_switch_off,
  output logic watchdog_expiry,
  output logic safety_timer_advance,
  output logic charge_terminate,
  output logic charge_current_suspend,
  output logic battery_switch_on,
  output logic power_good_irq,
  output logic charge_done_irq,
  output logic charge_state_irq,
  output logic temp_fault_irq,
  output logic battery_overvolt_irq
);
  // ****************************************
  // Serial pins
  // ****************************************
  logic scl_s;
  logic sda_s;
  logic scl_d_r;
  logic sda_d_r;
  logic scl_rise;
  logic scl_fall;
  logic bus_start;
  logic bus_stop;

  // Pins come from another domain, so two flops before any decode
  cc_sync #(.W(2), .INIT(2'b11)) u_sync (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .d({scl_in, sda_in}),
    .q({scl_s, sda_s})
  );

  // Previous synchronised levels for edge and condition detection
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
    end else begin
      scl_d_r <= scl_s;
      sda_d_r <= sda_s;
    end
  end

  assign scl_rise = scl_s && !scl_d_r;
  assign scl_fall = !scl_s && scl_d_r;
  assign bus_start = scl_s && scl_d_r && sda_d_r && !sda_s;
  assign bus_stop = scl_s && scl_d_r && !sda_d_r && sda_s;
  assign sda_out = 1'b0; // Open drain: only ever pulls low

  // ****************************************
  // Register file
  // ****************************************
  localparam logic [23:0] DEF_ALL = {CC_DEF_MISC, CC_DEF_TMR, CC_DEF_VOLT};
  localparam logic [23:0] WDK_ALL = {CC_WDK_MISC, CC_WDK_TMR, CC_WDK_VOLT};
  logic [7:0] cfg_r [CC_NREG];
  logic [7:0] cfg_nxt [CC_NREG];
  logic [7:0] ptr_r;
  logic [7:0] ptr_nxt;
  logic [7:0] shift_r;
  logic [7:0] shift_nxt;
  logic [7:0] ptr_rel;
  logic ptr_hit;
  logic [7:0] rd_data;
  logic wr_en;
  logic wd_exp;

  assign ptr_rel = ptr_r - CC_OFS_VOLT;
  assign ptr_hit = ptr_rel < 8'(CC_NREG);
  // Unmapped pointers read as zero and swallow writes
  assign rd_data = ptr_hit ? cfg_r[ptr_rel[1:0]] : 8'h00;

  genvar gi;
  generate
    for (gi = 0; gi < CC_NREG; gi++) begin : g_reg
      logic sel;
      logic [7:0] dflt;
      logic [7:0] keep;
      assign sel = wr_en && ptr_hit && (ptr_rel[1:0] == 2'(gi));
      assign dflt = DEF_ALL[gi*8 +: 8];
      assign keep = WDK_ALL[gi*8 +: 8];
      // Register reset beats watchdog reload, which beats a host write
      assign cfg_nxt[gi] = register_reset ? dflt :
                           wd_exp ? ((cfg_r[gi] & ~keep) | (dflt & keep)) :
                           sel ? shift_r : cfg_r[gi];
      always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
          cfg_r[gi] <= DEF_ALL[gi*8 +: 8];
        end else begin
          cfg_r[gi] <= cfg_nxt[gi];
        end
      end
    end
  endgenerate

  // ****************************************
  // Serial slave state machine
  // ****************************************
  cc_i2c_state_type state_r;
  cc_i2c_state_type state_nxt;
  logic [3:0] cnt_r;
  logic [3:0] cnt_nxt;
  logic [7:0] tx_r;
  logic [7:0] tx_nxt;
  logic rw_r;
  logic rw_nxt;
  logic nack_r;
  logic nack_nxt;
  logic acc_r;
  logic acc_nxt;
  logic sda_lo_r;
  logic sda_lo_nxt;
  logic host_kick;

  // Stop and start are honoured in any state; a start also acts as repeated start
  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    shift_nxt = shift_r;
    ptr_nxt = ptr_r;
    tx_nxt = tx_r;
    rw_nxt = rw_r;
    nack_nxt = nack_r;
    acc_nxt = acc_r;
    sda_lo_nxt = sda_lo_r;
    wr_en = 1'b0;
    host_kick = 1'b0;
    if (bus_stop) begin
      state_nxt = CC_IDLE;
      sda_lo_nxt = 1'b0;
      host_kick = acc_r;
      acc_nxt = 1'b0;
    end else if (bus_start) begin
      state_nxt = CC_ADDR;
      cnt_nxt = 4'd0;
      sda_lo_nxt = 1'b0;
    end else begin
      case (state_r)
        CC_ADDR, CC_PTR, CC_WDATA: begin
          if (scl_rise) begin
            shift_nxt = {shift_r[6:0], sda_s};
            cnt_nxt = cnt_r + 4'd1;
          end else if (scl_fall && cnt_r == 4'd8) begin
            cnt_nxt = 4'd0;
            sda_lo_nxt = 1'b1;
            if (state_r == CC_ADDR) begin
              if (shift_r[7:1] == CC_I2C_ADDR) begin
                state_nxt = CC_ACK_ADDR;
                rw_nxt = shift_r[0];
                acc_nxt = 1'b1;
              end else begin
                state_nxt = CC_IGNORE;
                sda_lo_nxt = 1'b0;
              end
            end else if (state_r == CC_PTR) begin
              ptr_nxt = shift_r;
              state_nxt = CC_ACK_PTR;
            end else begin
              wr_en = 1'b1;
              state_nxt = CC_ACK_WR;
            end
          end
        end
        CC_ACK_ADDR, CC_ACK_PTR, CC_ACK_WR: begin
          if (scl_fall) begin
            sda_lo_nxt = 1'b0;
            cnt_nxt = 4'd0;
            if (state_r == CC_ACK_WR) begin
              ptr_nxt = ptr_r + 8'd1;
            end
            if (state_r == CC_ACK_ADDR && rw_r) begin
              state_nxt = CC_RDATA;
              tx_nxt = rd_data;
              sda_lo_nxt = !rd_data[7];
            end else if (state_r == CC_ACK_ADDR) begin
              state_nxt = CC_PTR;
            end else begin
              state_nxt = CC_WDATA;
            end
          end
        end
        CC_RDATA: begin
          if (scl_fall) begin
            if (cnt_r == 4'd7) begin
              state_nxt = CC_RACK;
              sda_lo_nxt = 1'b0;
              ptr_nxt = ptr_r + 8'd1;
            end else begin
              tx_nxt = {tx_r[6:0], 1'b0};
              sda_lo_nxt = !tx_r[6];
              cnt_nxt = cnt_r + 4'd1;
            end
          end
        end
        CC_RACK: begin
          if (scl_rise) begin
            nack_nxt = sda_s;
          end else if (scl_fall) begin
            cnt_nxt = 4'd0;
            if (nack_r) begin
              state_nxt = CC_IGNORE;
            end else begin
              state_nxt = CC_RDATA;
              tx_nxt = rd_data;
              sda_lo_nxt = !rd_data[7];
            end
          end
        end
        default: begin
          state_nxt = state_r;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_r <= CC_IDLE;
      cnt_r <= '0;
      shift_r <= '0;
      ptr_r <= '0;
      tx_r <= '0;
      rw_r <= 1'b0;
      nack_r <= 1'b0;
      acc_r <= 1'b0;
      sda_lo_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      shift_r <= shift_nxt;
      ptr_r <= ptr_nxt;
      tx_r <= tx_nxt;
      rw_r <= rw_nxt;
      nack_r <= nack_nxt;
      acc_r <= acc_nxt;
      sda_lo_r <= sda_lo_nxt;
    end
  end

  assign sda_oe = sda_lo_r;

  // ****************************************
  // Field decode
  // ****************************************
  assign charge_target_voltage = cfg_r[0][CC_B_VT +: 6];
  // Linear code to millivolts, 4545 at full scale
  assign charge_target_mv = 13'(CC_VT_BASE_MV + CC_VT_STEP_MV * int'(charge_target_voltage));
  assign precharge_handover_level = cfg_r[0][CC_B_PRE];
  assign precharge_handover_mv = precharge_handover_level ? CC_PRE_HI_MV : CC_PRE_LO_MV;
  assign recharge_margin = cfg_r[0][CC_B_RECH];
  assign recharge_margin_mv = recharge_margin ? CC_RECH_HI_MV : CC_RECH_LO_MV;
  assign discharge_watchdog_on = cfg_r[1][CC_B_DWD];
  assign watchdog_limit_s = (cfg_r[1][CC_B_WDL +: 2] == 2'b00) ? 8'd0 :
                            (cfg_r[1][CC_B_WDL +: 2] == 2'b01) ? CC_WD_S1 :
                            (cfg_r[1][CC_B_WDL +: 2] == 2'b10) ? CC_WD_S2 : CC_WD_S3;
  assign termination_enable = cfg_r[1][CC_B_TERM];
  assign safety_timer_enable = cfg_r[1][CC_B_STMR];
  assign fast_charge_time_limit = cfg_r[1][CC_B_CTL +: 2];
  assign fast_charge_hours = (fast_charge_time_limit == 2'b00) ? CC_HR0 :
                             (fast_charge_time_limit == 2'b01) ? CC_HR1 :
                             (fast_charge_time_limit == 2'b10) ? CC_HR2 : CC_HR3;
  assign post_termination_keep_current = cfg_r[1][CC_B_KEEP];
  assign temp_sense_on = cfg_r[2][CC_B_NTC];
  assign safety_timer_double = cfg_r[2][CC_B_DBL];
  assign battery_switch_off = cfg_r[2][CC_B_BSW];

  // ****************************************
  // Watchdog and charger controls
  // ****************************************
  cc_watchdog #(.TICK_CYC(TICK_CYC)) u_wdog (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .limit_code(cfg_r[1][CC_B_WDL +: 2]),
    .discharge_mode(discharge_mode),
    .discharge_watchdog_on(discharge_watchdog_on),
    .kick(host_kick || watchdog_restart),
    .watchdog_expiry(wd_exp)
  );
  assign watchdog_expiry = wd_exp;

  logic half_r;
  logic dbl_act;
  logic [CC_NIRQ-1:0] evt;
  logic [CC_NIRQ-1:0] irq_r;
  assign dbl_act = safety_timer_double && power_path_limiting;
  assign evt = {power_good_evt, charge_done_evt, charge_state_evt, temp_fault_evt, battery_overvolt_evt};

  // Half rate drops every other base tick while limiting with safety_timer_double set, so the limit doubles
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      half_r <= 1'b0;
      safety_timer_advance <= 1'b0;
      charge_terminate <= 1'b0;
      charge_current_suspend <= 1'b0;
      battery_switch_on <= 1'b0;
    end else begin
      if (safety_base_tick && dbl_act) begin
        half_r <= !half_r;
      end
      safety_timer_advance <= safety_base_tick && safety_timer_enable && (!dbl_act || half_r);
      charge_terminate <= term_current_low && termination_enable;
      charge_current_suspend <= term_current_low && termination_enable && !post_termination_keep_current;
      battery_switch_on <= battery_switch_request && !battery_switch_off;
    end
  end

  // Mask bits sit in the same order as the event vector
  generate
    for (gi = 0; gi < CC_NIRQ; gi++) begin : g_irq
      always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
          irq_r[gi] <= 1'b0;
        end else begin
          irq_r[gi] <= evt[gi] && !cfg_r[2][CC_B_MASK + gi];
        end
      end
    end
  endgenerate

  assign {power_good_irq, charge_done_irq, charge_state_irq, temp_fault_irq, battery_overvolt_irq} = irq_r;
endmodule : cc_charge_config_regs

// file: logic/cc_pkg.sv
package cc_pkg;
  // ****************************************
  // Register map
  // ****************************************
  localparam logic [7:0] CC_OFS_VOLT = 8'h04;
  localparam logic [7:0] CC_OFS_TMR = 8'h05;
  localparam logic [7:0] CC_OFS_MISC = 8'h06;
  localparam int CC_NREG = 3;
  localparam logic [7:0] CC_DEF_VOLT = 8'ha3;
  localparam logic [7:0] CC_DEF_TMR = 8'h3a;
  localparam logic [7:0] CC_DEF_MISC = 8'hc0;
  // Bits that reload on watchdog expiry, one per field bit
  localparam logic [7:0] CC_WDK_VOLT = 8'hff;
  localparam logic [7:0] CC_WDK_TMR = 8'h1f;
  localparam logic [7:0] CC_WDK_MISC = 8'hdf;
  // ****************************************
  // Field positions
  // ****************************************
  localparam int CC_B_VT = 2;
  localparam int CC_B_PRE = 1;
  localparam int CC_B_RECH = 0;
  localparam int CC_B_DWD = 7;
  localparam int CC_B_WDL = 5;
  localparam int CC_B_TERM = 4;
  localparam int CC_B_STMR = 3;
  localparam int CC_B_CTL = 1;
  localparam int CC_B_KEEP = 0;
  localparam int CC_B_NTC = 7;
  localparam int CC_B_DBL = 6;
  localparam int CC_B_BSW = 5;
  localparam int CC_B_MASK = 0;
  localparam int CC_NIRQ = 5;
  // ****************************************
  // Field meanings and timing
  // ****************************************
  localparam int CC_VT_BASE_MV = 3600;
  localparam int CC_VT_STEP_MV = 15;
  localparam logic [11:0] CC_PRE_LO_MV = 12'd2800;
  localparam logic [11:0] CC_PRE_HI_MV = 12'd3000;
  localparam logic [7:0] CC_RECH_LO_MV = 8'd100;
  localparam logic [7:0] CC_RECH_HI_MV = 8'd200;
  localparam logic [7:0] CC_WD_S1 = 8'd40;
  localparam logic [7:0] CC_WD_S2 = 8'd80;
  localparam logic [7:0] CC_WD_S3 = 8'd160;
  localparam logic [3:0] CC_HR0 = 4'd3;
  localparam logic [3:0] CC_HR1 = 4'd5;
  localparam logic [3:0] CC_HR2 = 4'd8;
  localparam logic [3:0] CC_HR3 = 4'd12;
  localparam int CC_CLK_KHZ = 50000;
  localparam int CC_SEC_MS = 1000;
  localparam int CC_SEC_CYC = CC_SEC_MS * CC_CLK_KHZ;
  localparam logic [6:0] CC_I2C_ADDR = 7'h07;
  typedef enum logic [3:0] {
    CC_IDLE, CC_ADDR, CC_ACK_ADDR, CC_PTR, CC_ACK_PTR,
    CC_WDATA, CC_ACK_WR, CC_RDATA, CC_RACK, CC_IGNORE
  } cc_i2c_state_type;
endpackage : cc_pkg

// file: logic/cc_sync.sv
`timescale 1ns/1ps
// Two-flop synchroniser, one chain per bit
module cc_sync #(
  parameter int W = 2,
  parameter logic [W-1:0] INIT = '1
) (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_r;
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
          meta_r[i] <= INIT[i];
          q[i] <= INIT[i];
        end else begin
          meta_r[i] <= d[i];
          q[i] <= meta_r[i];
        end
      end
    end
  endgenerate
endmodule : cc_sync

// file: logic/cc_watchdog.sv
`timescale 1ns/1ps
module cc_watchdog
  import cc_pkg::*;
#(
  parameter int TICK_CYC = CC_SEC_CYC
) (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic [1:0] limit_code,
  input wire logic discharge_mode,
  input wire logic discharge_watchdog_on,
  input wire logic kick,
  output logic watchdog_expiry
);
  logic [31:0] pre_r;
  logic [7:0] sec_r;
  logic [7:0] limit_s;
  logic run;
  logic tick;
  // Code 00 stops the timer whatever the discharge bit says
  assign run = (limit_code != 2'b00) && (!discharge_mode || discharge_watchdog_on);
  assign limit_s = (limit_code == 2'b01) ? CC_WD_S1 :
                   (limit_code == 2'b10) ? CC_WD_S2 : CC_WD_S3;
  assign tick = (pre_r == 32'(TICK_CYC - 1));
  // One-second prescaler, then whole seconds; a stopped timer restarts from zero
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      pre_r <= '0;
      sec_r <= '0;
      watchdog_expiry <= 1'b0;
    end else begin
      watchdog_expiry <= 1'b0;
      if (!run || kick) begin
        pre_r <= '0;
        sec_r <= '0;
      end else if (tick) begin
        pre_r <= '0;
        if (sec_r == limit_s - 8'd1) begin
          sec_r <= '0;
          watchdog_expiry <= 1'b1;
        end else begin
          sec_r <= sec_r + 8'd1;
        end
      end else begin
        pre_r <= pre_r + 32'd1;
      end
    end
  end
endmodule : cc_watchdog
